// File: logic/xfer_arith_pkg.sv
// Shared types, constants and helper functions of the transfer and arithmetic datapath.
package xfer_arith_pkg;

  typedef enum logic [1:0] {SZ_B = 2'h0, SZ_W = 2'h1, SZ_L = 2'h2} size_t;

  typedef enum logic [4:0] {
    OP_XFER_RR    = 5'h00, OP_XFER_IMM   = 5'h01, OP_XFER_LOAD  = 5'h02,
    OP_XFER_STORE = 5'h03, OP_PERIPH_RD  = 5'h04, OP_PERIPH_WR  = 5'h05,
    OP_STACK_PULL = 5'h06, OP_STACK_PUT  = 5'h07, OP_RESTORE    = 5'h08,
    OP_SAVE       = 5'h09, OP_SUM        = 5'h0a, OP_DIFF       = 5'h0b,
    OP_SUM_C      = 5'h0c, OP_DIFF_B     = 5'h0d, OP_STEP_UP    = 5'h0e,
    OP_STEP_DOWN  = 5'h0f, OP_WIDE_PLUS  = 5'h10, OP_WIDE_MINUS = 5'h11,
    OP_BCD_SUM    = 5'h12, OP_BCD_DIFF   = 5'h13, OP_UMUL       = 5'h14,
    OP_SMUL       = 5'h15, OP_UDIV       = 5'h16, OP_SDIV       = 5'h17,
    OP_FLAG_DIFF  = 5'h18
  } op_t;

  // Condition flags: half carry, negative, zero, overflow, carry.
  typedef struct packed {logic h; logic n; logic z; logic v; logic c;} flags_t;

  // One decoded instruction from the sequencer.
  typedef struct packed {
    op_t         op;
    size_t       size;
    logic [3:0]  rd;
    logic [3:0]  rs;
    logic        use_imm;
    logic [31:0] imm;
    logic [31:0] ea;
    logic [7:0]  reg_list;
  } instr_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    size_t       size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {logic ack; logic [31:0] rdata;} mem_rsp_t;

  localparam logic [2:0]  SP_IDX       = 3'h7;
  localparam logic [7:0]  LIST_USABLE  = 8'h7f;
  localparam logic [31:0] EVEN_MASK    = 32'hffff_fffe;
  localparam logic [31:0] BYTES_B      = 32'h0000_0001;
  localparam logic [31:0] BYTES_W      = 32'h0000_0002;
  localparam logic [31:0] BYTES_L      = 32'h0000_0004;
  localparam logic [7:0]  BCD_LO_ADJ   = 8'h06;
  localparam logic [7:0]  BCD_HI_ADJ   = 8'h60;
  localparam logic [7:0]  BCD_BYTE_MAX = 8'h99;
  localparam logic [3:0]  BCD_DIGIT_MAX = 4'h9;

  function automatic logic [31:0] size_mask(input size_t sz);
    case (sz)
      SZ_B:    size_mask = 32'h0000_00ff;
      SZ_W:    size_mask = 32'h0000_ffff;
      default: size_mask = 32'hffff_ffff;
    endcase
  endfunction

  function automatic logic [31:0] size_bytes(input size_t sz);
    case (sz)
      SZ_B:    size_bytes = BYTES_B;
      SZ_W:    size_bytes = BYTES_W;
      default: size_bytes = BYTES_L;
    endcase
  endfunction

  function automatic logic top_bit(input logic [31:0] v, input size_t sz);
    case (sz)
      SZ_B:    top_bit = v[7];
      SZ_W:    top_bit = v[15];
      default: top_bit = v[31];
    endcase
  endfunction

endpackage

// File: logic/arith_unit.sv
// Combinational arithmetic unit: sums, differences, BCD fix, products and quotients.
`timescale 1ns/100ps
module arith_unit (
  input  xfer_arith_pkg::op_t    op,    // Operation to perform.
  input  xfer_arith_pkg::size_t  size,  // Operand size.
  input  wire logic [31:0]       a,     // Destination operand.
  input  wire logic [31:0]       b,     // Source or immediate operand.
  input  xfer_arith_pkg::flags_t fin,   // Current condition flags.
  output logic [31:0]            res,   // Result, low bits meaningful.
  output xfer_arith_pkg::flags_t fout,  // Updated condition flags.
  output logic                   wr     // Result is to be written back.
);
  import xfer_arith_pkg::*;

  // One adder serves every sum, difference and compare; flags are cut at the operand size.
  always_comb begin
    logic [31:0] m;
    logic [31:0] bb;
    logic [32:0] sum;
    logic [31:0] hx;
    logic        sub;
    logic        cin;
    logic        cout;
    logic        sgn;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] prod;
    logic        neg_d;
    logic        neg_s;
    logic [31:0] mag_d;
    logic [31:0] mag_s;
    logic [31:0] q;
    logic [31:0] r;
    logic [7:0]  adj;
    m     = size_mask(size);
    sub   = (op == OP_DIFF) || (op == OP_DIFF_B) || (op == OP_FLAG_DIFF) ||
            (op == OP_STEP_DOWN) || (op == OP_WIDE_MINUS);
    cin   = ((op == OP_SUM_C) || (op == OP_DIFF_B)) ? fin.c : 1'b0;
    bb    = (sub ? ~b : b) & m;
    sum   = {1'b0, a & m} + {1'b0, bb} + {32'h0000_0000, sub ^ cin};
    hx    = a ^ bb ^ sum[31:0];
    cout  = (size == SZ_B) ? sum[8] : (size == SZ_W) ? sum[16] : sum[32];
    sgn   = (op == OP_SMUL) || (op == OP_SDIV);
    opa   = (size == SZ_B) ? {{24{sgn & a[7]}}, a[7:0]} : {{16{sgn & a[15]}}, a[15:0]};
    opb   = (size == SZ_B) ? {{24{sgn & b[7]}}, b[7:0]} : {{16{sgn & b[15]}}, b[15:0]};
    prod  = opa * opb;
    // Quotients work on magnitudes; the signs are put back afterwards.
    neg_d = sgn & ((size == SZ_B) ? a[15] : a[31]);
    neg_s = sgn & ((size == SZ_B) ? b[7] : b[15]);
    mag_d = (size == SZ_B) ? {{16{neg_d}}, a[15:0]} : a;
    mag_d = neg_d ? (~mag_d + 32'h0000_0001) : mag_d;
    mag_s = neg_s ? (~opb + 32'h0000_0001) : opb;
    q     = (mag_s == 32'h0000_0000) ? 32'h0000_0000 : mag_d / mag_s;
    r     = (mag_s == 32'h0000_0000) ? 32'h0000_0000 : mag_d % mag_s;
    q     = (neg_d ^ neg_s) ? (~q + 32'h0000_0001) : q;
    r     = neg_d ? (~r + 32'h0000_0001) : r;
    adj   = 8'h00;
    res   = a;
    fout  = fin;
    wr    = 1'b0;
    case (op)
      OP_XFER_RR, OP_XFER_IMM, OP_XFER_LOAD, OP_XFER_STORE, OP_STACK_PULL,
      OP_STACK_PUT: begin
        res    = b & m;
        fout.n = top_bit(b, size);
        fout.z = ((b & m) == 32'h0000_0000);
        fout.v = 1'b0;
        wr     = 1'b1;
      end
      OP_SUM, OP_DIFF, OP_SUM_C, OP_DIFF_B, OP_FLAG_DIFF: begin
        res    = sum[31:0] & m;
        fout.h = sub ^ ((size == SZ_B) ? hx[4] : (size == SZ_W) ? hx[12] : hx[28]);
        fout.c = sub ^ cout;
        fout.n = top_bit(sum[31:0], size);
        fout.v = (top_bit(a, size) == top_bit(bb, size)) &&
                 (top_bit(sum[31:0], size) != top_bit(a, size));
        // Carry chains only clear the zero flag, so multi-byte results test zero as a whole.
        fout.z = ((sum[31:0] & m) == 32'h0000_0000) &
                 (((op == OP_SUM_C) || (op == OP_DIFF_B)) ? fin.z : 1'b1);
        wr     = (op != OP_FLAG_DIFF);
      end
      OP_STEP_UP, OP_STEP_DOWN: begin
        res    = sum[31:0] & m;
        fout.n = top_bit(sum[31:0], size);
        fout.z = ((sum[31:0] & m) == 32'h0000_0000);
        fout.v = (top_bit(a, size) == top_bit(bb, size)) &&
                 (top_bit(sum[31:0], size) != top_bit(a, size));
        wr     = 1'b1;
      end
      OP_WIDE_PLUS, OP_WIDE_MINUS: begin
        res = sum[31:0];
        wr  = 1'b1;
      end
      OP_BCD_SUM: begin
        if (fin.h || (a[3:0] > BCD_DIGIT_MAX)) begin
          adj = adj | BCD_LO_ADJ;
        end
        if (fin.c || (a[7:0] > BCD_BYTE_MAX)) begin
          adj    = adj | BCD_HI_ADJ;
          fout.c = 1'b1;
        end
        res    = {24'h00_0000, a[7:0] + adj};
        fout.n = res[7];
        fout.z = (res[7:0] == 8'h00);
        wr     = 1'b1;
      end
      OP_BCD_DIFF: begin
        adj    = (fin.h ? BCD_LO_ADJ : 8'h00) | (fin.c ? BCD_HI_ADJ : 8'h00);
        res    = {24'h00_0000, a[7:0] - adj};
        fout.n = res[7];
        fout.z = (res[7:0] == 8'h00);
        wr     = 1'b1;
      end
      OP_UMUL, OP_SMUL: begin
        res = (size == SZ_B) ? {16'h0000, prod[15:0]} : prod;
        if (sgn) begin
          fout.n = (size == SZ_B) ? prod[15] : prod[31];
          fout.z = (res == 32'h0000_0000);
        end
        wr = 1'b1;
      end
      OP_UDIV, OP_SDIV: begin
        // Remainder in the upper half, quotient in the lower half.
        res    = (size == SZ_B) ? {16'h0000, r[7:0], q[7:0]} : {r[15:0], q[15:0]};
        fout.n = top_bit(opb, size) ^ neg_d;
        fout.z = (mag_s == 32'h0000_0000);
        wr     = (mag_s != 32'h0000_0000);
      end
      default: begin
        wr = 1'b0;
      end
    endcase
  end

endmodule

// File: logic/transfer_arith_datapath.sv
// Transfer and arithmetic datapath with its own register file, flags and memory port.
`timescale 1ns/100ps
module transfer_arith_datapath (
  input  wire logic                 mclk,      // Core clock, 50 MHz.
  input  wire logic                 rst_n,     // Asynchronous reset, active low.
  input  wire logic                 start,     // Instruction offered this cycle.
  input  xfer_arith_pkg::instr_t    instr,     // Decoded instruction.
  input  xfer_arith_pkg::mem_rsp_t  mem_rsp,   // Memory answer.
  output xfer_arith_pkg::mem_req_t  mem_req,   // Memory request, held until ack.
  output logic                      busy,      // Memory sequence in progress.
  output logic                      done,      // Instruction finished, one cycle.
  output logic                      illegal,   // Instruction refused, one cycle.
  output xfer_arith_pkg::flags_t    flags,     // Condition flags.
  output logic [7:0][31:0]          reg_file   // General registers.
);
  import xfer_arith_pkg::*;

  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_MEM = 2'h2} state_t;

  typedef struct packed {
    state_t           st;
    logic [7:0][31:0] regs;
    flags_t           flags;
    instr_t           cur;
    logic [7:0]       pending;
    logic [2:0]       idx;
    mem_req_t         req;
    logic             done;
    logic             illegal;
    logic             busy;
  } core_state_t;

  core_state_t s;
  core_state_t next_s;

  // Register slice read by operand size.
  function automatic logic [31:0] rd_op(input logic [7:0][31:0] rf, input logic [3:0] i,
                                        input size_t sz);
    case (sz)
      SZ_B:    rd_op = {24'h00_0000, i[3] ? rf[i[2:0]][7:0] : rf[i[2:0]][15:8]};
      SZ_W:    rd_op = {16'h0000, i[3] ? rf[i[2:0]][31:16] : rf[i[2:0]][15:0]};
      default: rd_op = rf[i[2:0]];
    endcase
  endfunction

  // Register slice write by operand size; the rest of the longword is kept.
  function automatic logic [31:0] wr_op(input logic [31:0] old, input logic hi_sel,
                                        input size_t sz, input logic [31:0] v);
    wr_op = old;
    case (sz)
      SZ_B: begin
        if (hi_sel) wr_op[7:0] = v[7:0];
        else wr_op[15:8] = v[7:0];
      end
      SZ_W: begin
        if (hi_sel) wr_op[31:16] = v[15:0];
        else wr_op[15:0] = v[15:0];
      end
      default: wr_op = v;
    endcase
  endfunction

  function automatic logic [31:0] align(input logic [31:0] ad, input size_t sz);
    align = (sz == SZ_B) ? ad : (ad & EVEN_MASK);
  endfunction

  // Highest set bit when high is set, else lowest set bit.
  function automatic logic [2:0] pick_reg(input logic [7:0] m, input logic high);
    pick_reg = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (high && m[i]) pick_reg = 3'(i);
      if (!high && m[7 - i]) pick_reg = 3'(7 - i);
    end
  endfunction

  instr_t      cur;
  size_t       dsz;
  op_t         alu_op;
  logic [31:0] alu_a;
  logic [31:0] alu_b;
  logic [31:0] alu_res;
  flags_t      alu_flags;
  logic        alu_wr;

  // Operand selection: the offered instruction while idle, the loaded word while waiting.
  always_comb begin
    logic wide;
    logic step;
    cur    = (s.st == ST_IDLE) ? instr : s.cur;
    wide   = (cur.op == OP_UMUL) || (cur.op == OP_SMUL) || (cur.op == OP_UDIV) ||
             (cur.op == OP_SDIV);
    step   = (cur.op == OP_STEP_UP) || (cur.op == OP_STEP_DOWN) ||
             (cur.op == OP_WIDE_PLUS) || (cur.op == OP_WIDE_MINUS);
    dsz    = wide ? ((cur.size == SZ_B) ? SZ_W : SZ_L) : cur.size;
    alu_op = cur.op;
    alu_a  = rd_op(s.regs, cur.rd, dsz);
    if (s.st == ST_MEM) begin
      alu_op = OP_XFER_LOAD;
      alu_b  = mem_rsp.rdata & size_mask(cur.size);
    end else if (step || cur.use_imm || (cur.op == OP_XFER_IMM)) begin
      alu_b  = cur.imm & size_mask(cur.size);
    end else begin
      alu_b  = rd_op(s.regs, cur.rs, cur.size);
    end
  end

  // The unit sees the operand size; byte products and quotients must not look like word ones.
  arith_unit u_arith (
    .op   (alu_op),
    .size (cur.size),
    .a    (alu_a),
    .b    (alu_b),
    .fin  (s.flags),
    .res  (alu_res),
    .fout (alu_flags),
    .wr   (alu_wr)
  );

  // Instruction acceptance, checks and the memory sequence.
  always_comb begin
    logic        bad;
    logic        multi;
    logic [7:0]  rem;
    logic [2:0]  pk;
    logic [31:0] sp;
    logic [31:0] nb;
    pk             = 3'h0;
    next_s         = s;
    next_s.done    = 1'b0;
    next_s.illegal = 1'b0;
    multi          = 1'b0;
    rem            = 8'h00;
    sp             = s.regs[SP_IDX];
    nb             = size_bytes(cur.size);
    bad            = 1'b0;
    case (s.st)
      ST_IDLE: begin
        if (start) begin
          case (instr.op)
            OP_PERIPH_RD, OP_PERIPH_WR: bad = 1'b1;
            OP_DIFF: bad = instr.use_imm && (instr.size == SZ_B);
            OP_SUM_C, OP_DIFF_B, OP_BCD_SUM, OP_BCD_DIFF:
              bad = (instr.size != SZ_B);
            OP_STEP_UP, OP_STEP_DOWN:
              bad = !((instr.imm == BYTES_B) ||
                      ((instr.imm == BYTES_W) && (instr.size != SZ_B)));
            OP_WIDE_PLUS, OP_WIDE_MINUS:
              bad = (instr.size != SZ_L) || !((instr.imm == BYTES_B) ||
                    (instr.imm == BYTES_W) || (instr.imm == BYTES_L));
            OP_UMUL, OP_SMUL, OP_UDIV, OP_SDIV: bad = (instr.size == SZ_L);
            OP_STACK_PULL, OP_STACK_PUT: bad = (instr.size == SZ_B);
            OP_RESTORE, OP_SAVE: begin
              rem = instr.reg_list & LIST_USABLE;
              bad = ((rem & (rem - 8'h01)) == 8'h00);
            end
            default: bad = 1'b0;
          endcase
          next_s.cur = instr;
          if (bad) begin
            next_s.illegal = 1'b1;
            next_s.done    = 1'b1;
          end else begin
            case (instr.op)
              OP_XFER_LOAD: begin
                next_s.req = '{1'b1, 1'b0, instr.size, align(instr.ea, instr.size),
                               32'h0000_0000};
              end
              OP_XFER_STORE: begin
                next_s.flags = alu_flags;
                next_s.req   = '{1'b1, 1'b1, instr.size, align(instr.ea, instr.size), alu_b};
              end
              OP_STACK_PULL: begin
                next_s.req          = '{1'b1, 1'b0, instr.size, align(sp, instr.size),
                                        32'h0000_0000};
                next_s.regs[SP_IDX] = sp + nb;
              end
              OP_STACK_PUT: begin
                next_s.flags        = alu_flags;
                next_s.regs[SP_IDX] = sp - nb;
                next_s.req          = '{1'b1, 1'b1, instr.size, align(sp - nb, instr.size),
                                        alu_b};
              end
              OP_RESTORE, OP_SAVE: multi = 1'b1;
              default: begin
                if (alu_wr) begin
                  next_s.regs[instr.rd[2:0]] = wr_op(s.regs[instr.rd[2:0]], instr.rd[3], dsz,
                                                     alu_res);
                end
                next_s.flags = alu_flags;
                next_s.done  = 1'b1;
              end
            endcase
            if ((instr.op == OP_XFER_LOAD) || (instr.op == OP_XFER_STORE) ||
                (instr.op == OP_STACK_PULL) || (instr.op == OP_STACK_PUT) || multi) begin
              next_s.st   = ST_MEM;
              next_s.busy = 1'b1;
            end
          end
        end
      end
      ST_MEM: begin
        if (mem_rsp.ack) begin
          next_s.req.valid = 1'b0;
          case (s.cur.op)
            OP_XFER_LOAD, OP_STACK_PULL: begin
              next_s.regs[s.cur.rd[2:0]] = wr_op(s.regs[s.cur.rd[2:0]], s.cur.rd[3],
                                                 s.cur.size, alu_res);
              next_s.flags = alu_flags;
            end
            OP_RESTORE: next_s.regs[s.idx] = mem_rsp.rdata;
            default: next_s.flags = s.flags;
          endcase
          if (((s.cur.op == OP_RESTORE) || (s.cur.op == OP_SAVE)) && (s.pending != 8'h00)) begin
            multi = 1'b1;
            rem   = s.pending;
          end else begin
            next_s.st   = ST_IDLE;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
          end
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    // One longword of a list: saves go highest first downward, restores lowest first upward.
    if (multi) begin
      pk             = pick_reg(rem, cur.op == OP_SAVE);
      next_s.idx     = pk;
      next_s.pending = rem & ~(8'h01 << pk);
      if (cur.op == OP_SAVE) begin
        next_s.regs[SP_IDX] = sp - BYTES_L;
        next_s.req = '{1'b1, 1'b1, SZ_L, align(sp - BYTES_L, SZ_L), s.regs[pk]};
      end else begin
        next_s.regs[SP_IDX] = sp + BYTES_L;
        next_s.req = '{1'b1, 1'b0, SZ_L, align(sp, SZ_L), 32'h0000_0000};
      end
    end
  end

  // The whole state is one register; reset leaves registers and flags cleared.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s    <= '0;
      s.st <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign mem_req  = s.req;
  assign busy     = s.busy;
  assign done     = s.done;
  assign illegal  = s.illegal;
  assign flags    = s.flags;
  assign reg_file = s.regs;

endmodule

// File: testbench/transfer_arith_datapath_properties.sv
// Port-level properties of the transfer and arithmetic datapath.
`timescale 1ns/100ps
module datapath_properties (
  input wire logic                 mclk,     // Clock.
  input wire logic                 rst_n,    // Reset, low.
  input wire logic                 start,    // Offer.
  input xfer_arith_pkg::instr_t    instr,    // Instruction.
  input xfer_arith_pkg::mem_rsp_t  mem_rsp,  // Memory answer.
  input xfer_arith_pkg::mem_req_t  mem_req,  // Memory request.
  input wire logic                 busy,     // Sequence running.
  input wire logic                 done,     // Finished.
  input wire logic                 illegal,  // Refused.
  input xfer_arith_pkg::flags_t    flags,    // Flags.
  input wire logic [7:0][31:0]     reg_file  // Registers.
);
  import xfer_arith_pkg::*;
  logic go;
  // An offer counts only while no memory sequence runs.
  assign go = start & ~busy;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_SUM_ONE_CYCLE: assert property (
    go && instr.op == OP_SUM |=> done && !mem_req.valid) else $error("sum not done in one cycle");
  AST_PERIPH_REFUSED: assert property (
    go && instr.op inside {OP_PERIPH_RD, OP_PERIPH_WR} |=> done && illegal)
    else $error("peripheral transfer accepted");
  AST_DIFF_BYTE_IMM: assert property (
    go && instr.op == OP_DIFF && instr.use_imm && instr.size == SZ_B |=> illegal)
    else $error("byte immediate difference accepted");
  AST_WIDE_NO_FLAGS: assert property (
    go && instr.op inside {OP_WIDE_PLUS, OP_WIDE_MINUS} |=> $stable(flags))
    else $error("wide offset changed flags");
  AST_CMP_KEEPS_REGS: assert property (
    go && instr.op == OP_FLAG_DIFF |=> $stable(reg_file)) else $error("compare wrote a register");
  AST_PUT_PREDEC: assert property (
    go && instr.op == OP_STACK_PUT && instr.size == SZ_L |=> mem_req.valid && mem_req.write
    && mem_req.addr == (($past(reg_file[7]) - BYTES_L) & EVEN_MASK))
    else $error("stack store address wrong");
  AST_PULL_POSTINC: assert property (
    go && instr.op == OP_STACK_PULL && instr.size == SZ_W |=> mem_req.valid && !mem_req.write
    && mem_req.addr == ($past(reg_file[7]) & EVEN_MASK)
    && reg_file[7] == $past(reg_file[7]) + BYTES_W) else $error("stack pull wrong");
  AST_LIST_LONG: assert property (
    go && instr.op inside {OP_SAVE, OP_RESTORE} && $countones(instr.reg_list & LIST_USABLE) > 1
    |=> mem_req.valid && mem_req.size == SZ_L && mem_req.write == ($past(instr.op) == OP_SAVE))
    else $error("list access not longword");
  AST_EVEN_ADDR: assert property (
    mem_req.valid && mem_req.size != SZ_B |-> !mem_req.addr[0]) else $error("odd wide address");
  AST_REQ_HELD: assert property (
    mem_req.valid && !mem_rsp.ack |=> $stable(mem_req)) else $error("request moved before ack");
  // Main scenarios worth seeing at least once.
  cover property (go && instr.op == OP_SAVE);
  cover property (mem_rsp.ack && !mem_req.write);
  cover property (illegal);
endmodule

// File: testbench/mem_partner.sv
// Byte memory answering the datapath's memory port after a chosen wait.
`timescale 1ns/100ps
module mem_partner (
  input  wire logic                mclk,  // Clock.
  input  wire logic                rst_n, // Reset, low.
  input  xfer_arith_pkg::mem_req_t req,   // Request.
  input  wire logic [1:0]          lat,   // Extra wait cycles.
  output xfer_arith_pkg::mem_rsp_t rsp    // Answer.
);
  import xfer_arith_pkg::*;
  logic [7:0] mem [0:255];
  logic [7:0] a;
  logic [1:0] cnt;
  assign a = req.addr[7:0];
  // Big-endian bytes; a rest cycle after each ack keeps a request from being answered twice.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= '0;
      cnt <= 2'h0;
    end else if (req.valid && !rsp.ack && cnt >= lat) begin
      cnt <= 2'h0;
      rsp.ack <= 1'b1;
      if (req.write && req.size == SZ_L)
        {mem[a], mem[a + 8'h1], mem[a + 8'h2], mem[a + 8'h3]} <= req.wdata;
      else if (req.write && req.size == SZ_W)
        {mem[a], mem[a + 8'h1]} <= req.wdata[15:0];
      else if (req.write)
        mem[a] <= req.wdata[7:0];
      else if (req.size == SZ_L)
        rsp.rdata <= {mem[a], mem[a + 8'h1], mem[a + 8'h2], mem[a + 8'h3]};
      else
        rsp.rdata <= req.size == SZ_B ? {24'h0, mem[a]} : {16'h0, mem[a], mem[a + 8'h1]};
    end else begin
      rsp.ack <= 1'b0;
      rsp.rdata <= ~rsp.rdata; // Released data must not look held.
      cnt <= (req.valid && !rsp.ack) ? cnt + 2'h1 : cnt;
    end
  end
endmodule

// File: testbench/test_transfer_arith_datapath.sv
// Self-checking bench for the transfer and arithmetic datapath.
`timescale 1ns/100ps
module test_transfer_arith_datapath;
  import xfer_arith_pkg::*;
  typedef struct packed {logic ill; logic [2:0] r; logic [31:0] v; logic [4:0] m, f;} note_t;
  logic             mclk = 0, rst_n = 0, start = 0, busy, done, illegal;
  logic [1:0]       lat = 0;
  logic [31:0]      seed = 32'h0000_0024, a, b;
  instr_t           instr = '0;
  mem_rsp_t         mem_rsp;
  mem_req_t         mem_req;
  flags_t           flags;
  logic [7:0][31:0] reg_file;
  note_t            q[$], got;
  int               n_fail = 0, n_checks = 0;
  always #10 mclk = ~mclk;
  transfer_arith_datapath i_dut (.mclk(mclk), .rst_n(rst_n), .start(start), .instr(instr),
    .mem_rsp(mem_rsp), .mem_req(mem_req), .busy(busy), .done(done), .illegal(illegal),
    .flags(flags), .reg_file(reg_file));
  mem_partner i_mem (.mclk(mclk), .rst_n(rst_n), .req(mem_req), .lat(lat), .rsp(mem_rsp));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Offer one instruction, note its outcome, drop start at the taking edge, wait for done.
  task automatic iss(op_t o, size_t s, logic [3:0] d, r, logic u, logic [31:0] im, ea,
                     logic [7:0] l, note_t n);
    int k;
    @(posedge mclk);
    start <= 1'b1;
    instr <= '{o, s, d, r, u, im, ea, l};
    lat <= 2'(xs() >> 30);
    q.push_back(n);
    @(posedge mclk);
    start <= 1'b0;
    k = 0;
    do @(posedge mclk); while (done !== 1'b1 && ++k < 40);
    if (k >= 40) cmp("done", 32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic ld(logic [2:0] x, logic [31:0] v);
    iss(OP_XFER_IMM, SZ_L, {1'b0, x}, 4'h0, 1, v, 32'h0, 8'h0, '{0, x, v, 0, 0});
  endtask
  // Immediate forms are the ones given a nonzero immediate.
  task automatic ar(op_t o, size_t s, logic [3:0] d, r, logic [31:0] im, logic [2:0] x,
                    logic [31:0] v, logic [4:0] m = 5'h00, logic [4:0] f = 5'h00);
    iss(o, s, d, r, im != 0, im, 32'h0, 8'h0, '{0, x, v, m, f});
  endtask
  task automatic mm(op_t o, size_t s, logic [3:0] d, logic [31:0] ea, logic [7:0] l,
                    logic [2:0] x, logic [31:0] v);
    iss(o, s, d, d, 0, 32'h0, ea, l, '{0, x, v, 0, 0});
  endtask
  task automatic bad(op_t o, size_t s, logic [31:0] im, logic [7:0] l);
    iss(o, s, 4'h8, 4'h9, 1, im, 32'h0, l, '{1, 0, 0, 0, 0});
  endtask
  // Each completion retires the oldest note.
  always @(posedge mclk) begin
    if (done === 1'b1) begin
      if (q.size() == 0) cmp("note", 32'h0, 32'h1);
      else begin
        got = q.pop_front();
        cmp("illegal", {31'h0, got.ill}, {31'h0, illegal});
        if (!got.ill) begin
          cmp("reg", got.v, reg_file[got.r]);
          cmp("flags", {27'h0, got.f}, {27'h0, flags & got.m});
        end
      end
    end
  end
  // The run needs well under a thousand cycles; ten thousand means a hang.
  initial begin
    #200_000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    a = xs();
    b = xs();
    ld(1, a);
    ld(2, b);
    ar(OP_XFER_RR, SZ_B, 4'h2, 4'h9, 0, 2, {b[31:16], a[7:0], b[7:0]});
    ar(OP_SUM, SZ_W, 4'h1, 4'ha, 0, 1, {a[31:16], a[15:0] + b[31:16]});
    ld(0, 32'h0000_0005);
    ar(OP_FLAG_DIFF, SZ_L, 4'h0, 4'h0, 32'h0000_0006, 0, 32'h0000_0005, 5'h0d, 5'h09);
    ar(OP_DIFF_B, SZ_B, 4'h8, 4'h0, 32'h0000_0020, 0, 32'h0000_00e4, 5'h01, 5'h01);
    ar(OP_SUM_C, SZ_B, 4'h8, 4'h0, 32'h0000_0001, 0, 32'h0000_00e6, 5'h01, 5'h00);
    ar(OP_STEP_UP, SZ_W, 4'h0, 4'h0, 32'h0000_0002, 0, 32'h0000_00e8);
    ar(OP_STEP_DOWN, SZ_B, 4'h8, 4'h0, 32'h0000_0001, 0, 32'h0000_00e7);
    ar(OP_WIDE_PLUS, SZ_L, 4'h0, 4'h0, 32'h0000_0004, 0, 32'h0000_00eb);
    ar(OP_WIDE_MINUS, SZ_L, 4'h0, 4'h0, 32'h0000_0002, 0, 32'h0000_00e9);
    ld(6, 32'h0000_0038);
    ld(5, 32'h0000_0019);
    ar(OP_SUM, SZ_B, 4'he, 4'h0, 32'h0000_0045, 6, 32'h0000_007d);
    ar(OP_BCD_SUM, SZ_B, 4'he, 4'h0, 32'h0, 6, 32'h0000_0083);
    ar(OP_DIFF, SZ_B, 4'he, 4'hd, 32'h0, 6, 32'h0000_006a);
    ar(OP_BCD_DIFF, SZ_B, 4'he, 4'h0, 32'h0, 6, 32'h0000_0064);
    ld(1, 32'h1234_0d0d);
    ld(2, 32'h0000_00f3);
    ar(OP_UMUL, SZ_B, 4'h1, 4'ha, 32'h0, 1, 32'h1234_0c57);
    ld(3, 32'h0000_fffe);
    ld(4, 32'h0000_0003);
    ar(OP_SMUL, SZ_W, 4'h3, 4'h4, 32'h0, 3, 32'hffff_fffa);
    ld(5, 32'h0000_0064);
    ld(6, 32'h0000_0007);
    ar(OP_UDIV, SZ_B, 4'h5, 4'he, 32'h0, 5, 32'h0000_020e);
    ld(0, 32'hffff_ff9c);
    ar(OP_SDIV, SZ_W, 4'h0, 4'h6, 32'h0, 0, 32'hfffe_fff2);
    ld(7, 32'h0000_0080);
    ld(1, a);
    mm(OP_STACK_PUT, SZ_L, 4'h1, 32'h0, 8'h00, 7, 32'h0000_007c);
    mm(OP_STACK_PULL, SZ_W, 4'h2, 32'h0, 8'h00, 2, {16'h0000, a[31:16]});
    mm(OP_XFER_LOAD, SZ_L, 4'h3, 32'h0000_007d, 8'h00, 3, a);
    mm(OP_XFER_STORE, SZ_W, 4'h1, 32'h0000_0041, 8'h00, 7, 32'h0000_007e);
    mm(OP_XFER_LOAD, SZ_B, 4'hc, 32'h0000_0041, 8'h00, 4, {24'h0, a[7:0]});
    mm(OP_XFER_STORE, SZ_B, 4'h1, 32'h0000_0041, 8'h00, 7, 32'h0000_007e);
    mm(OP_XFER_LOAD, SZ_W, 4'h4, 32'h0000_0041, 8'h00, 4, {16'h0, a[15:8], a[15:8]});
    mm(OP_SAVE, SZ_L, 4'h0, 32'h0, 8'h06, 7, 32'h0000_0076);
    ld(1, 32'h0000_0000);
    ld(2, 32'h0000_0000);
    mm(OP_RESTORE, SZ_L, 4'h0, 32'h0, 8'h06, 1, a);
    cmp("r2", {16'h0000, a[31:16]}, reg_file[2]);
    cmp("sp", 32'h0000_007e, reg_file[7]);
    bad(OP_PERIPH_RD, SZ_B, 32'h0, 8'h00);
    bad(OP_PERIPH_WR, SZ_B, 32'h0, 8'h00);
    bad(OP_DIFF, SZ_B, 32'h0000_0001, 8'h00);
    bad(OP_SUM_C, SZ_W, 32'h0000_0001, 8'h00);
    bad(OP_BCD_DIFF, SZ_W, 32'h0, 8'h00);
    bad(OP_STEP_UP, SZ_B, 32'h0000_0002, 8'h00);
    bad(OP_WIDE_PLUS, SZ_L, 32'h0000_0003, 8'h00);
    bad(OP_UMUL, SZ_L, 32'h0, 8'h00);
    bad(OP_STACK_PULL, SZ_B, 32'h0, 8'h00);
    bad(OP_SAVE, SZ_L, 32'h0, 8'h01);
    // Let the completion watcher retire the last note before the verdict.
    @(posedge mclk);
    tally_and_finish();
  end
endmodule
bind transfer_arith_datapath datapath_properties i_chk (.mclk(mclk), .rst_n(rst_n),
  .start(start), .instr(instr), .mem_rsp(mem_rsp), .mem_req(mem_req), .busy(busy),
  .done(done), .illegal(illegal), .flags(flags), .reg_file(reg_file));
